// [src/flash_pd_pkg.sv]
// constants, opcodes and state types of the power-down, quad and crc block
package flash_pd_pkg;
	// core clock rate and timing figures
	localparam int CORE_MHZ = 250;
	localparam int PD_ENTRY_NS = 3000;
	localparam int PD_RELEASE_NS = 30000;
	localparam int RESET_RECOVERY_NS = 40000;
	localparam int PD_ENTRY_CYC = (PD_ENTRY_NS * CORE_MHZ + 999) / 1000;
	localparam int PD_RELEASE_CYC = (PD_RELEASE_NS * CORE_MHZ + 999) / 1000;
	localparam int RESET_RECOVERY_CYC =
		(RESET_RECOVERY_NS * CORE_MHZ + 999) / 1000;
	localparam int TIMER_W = 16;

	// opcodes
	localparam logic [7:0] OP_PD_ENTER = 8'hb9;
	localparam logic [7:0] OP_PD_RELEASE = 8'hab;
	localparam logic [7:0] OP_QUAD_ON = 8'h35;
	localparam logic [7:0] OP_QUAD_OFF = 8'hf5;
	localparam logic [7:0] OP_CRC = 8'h9b;
	localparam logic [7:0] SUB_CRC = 8'h27;
	localparam logic [7:0] OPT_WHOLE = 8'hff;
	localparam logic [7:0] OPT_RANGE = 8'hfe;
	localparam logic [7:0] OP_READBACK = 8'h96;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;

	// byte positions inside a frame
	localparam logic [4:0] POS_OPCODE = 5'd0;
	localparam logic [4:0] POS_SUB = 5'd1;
	localparam logic [4:0] POS_OPTION = 5'd2;
	localparam logic [4:0] POS_EXP_FIRST = 5'd3;
	localparam logic [4:0] POS_EXP_LAST = 5'd10;
	localparam logic [4:0] POS_START_LAST = 5'd14;
	localparam logic [4:0] POS_STOP_LAST = 5'd18;
	localparam logic [4:0] CRC_WHOLE_BYTES = 5'd11;
	localparam logic [4:0] CRC_RANGE_BYTES = 5'd19;
	localparam logic [4:0] BYTE_CNT_MAX = 5'd31;
	localparam logic [5:0] EDGES_EXT = 6'd8;
	localparam logic [5:0] EDGES_QUAD = 6'd2;
	localparam logic [5:0] EDGE_CNT_MAX = 6'h3f;

	// crc and readback
	localparam logic [63:0] CRC_POLY = 64'h42f0e1eba9ea3693;
	localparam logic [63:0] CRC_INIT = 64'h0;
	localparam logic [63:0] RB_RESET = 64'h0;
	localparam logic [3:0] RB_BYTES = 4'd8;
	localparam logic [7:0] RB_BEYOND = 8'h00;
	localparam logic [31:0] ARRAY_LAST = 32'h00ff_ffff;

	// lanes driven during readback
	localparam logic [3:0] LANE_EXT_OUT = 4'h2;
	localparam logic [3:0] LANE_QUAD = 4'hf;

	typedef enum logic [1:0] {
		PWR_STANDBY = 2'b00,
		PWR_ENTERING = 2'b01,
		PWR_DOWN = 2'b11,
		PWR_WAKING = 2'b10
	} pwr_e;

	typedef enum logic [1:0] {
		CRC_IDLE = 2'b00,
		CRC_FETCH = 2'b01,
		CRC_FEED = 2'b11,
		CRC_CHECK = 2'b10
	} crc_e;
endpackage : flash_pd_pkg

// [src/crc_bus.sv]
// byte feed between the command core and the crc engine
`timescale 1ns/1ns
`default_nettype none
interface crc_bus;
	logic clear;
	logic valid;
	logic [7:0] data;
	logic [63:0] value;
	modport feeder(output clear, output valid, output data, input value);
	modport engine(input clear, input valid, input data, output value);
endinterface : crc_bus
`default_nettype wire

// [src/crc64_engine.sv]
// byte-wide crc-64 engine, data bits taken lsb first
`timescale 1ns/1ns
`default_nettype none
module crc64_engine
	import flash_pd_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// byte feed
	crc_bus.engine bus
);
	logic [63:0] crc;
	logic [63:0] next_crc;

	function automatic logic [63:0] crc_step(input logic [63:0] c,
		input logic [7:0] d);
		logic [63:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++) begin
			fb = r[63] ^ d[i];
			r = {r[62:0], 1'b0} ^ (fb ? CRC_POLY : 64'h0);
		end
		return r;
	endfunction : crc_step

	always_comb begin
		next_crc = crc;
		if (bus.clear) begin
			next_crc = CRC_INIT;
		end else if (bus.valid) begin
			next_crc = crc_step(crc, bus.data);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc <= CRC_INIT;
		end else begin
			crc <= next_crc;
		end
	end

	assign bus.value = crc;
endmodule : crc64_engine
`default_nettype wire

// [src/flash_pd_quad_crc.sv]
// power-down, quad protocol and crc check command handling
// Summary of operation
// - b9h with cs raised after eighth bit enters sleep after entry delay
// - power-down entry is rejected while a write is in progress
// - while asleep, ignore all but release, reset enable, reset; flags kept
// - release is abh alone; extra clocks with cs low void it
// - after release cs rise, standby follows the release delay; cs stays high
// - hardware reset leaves sleep at once; software reset leaves it after recovery time
// - 35h enters quad protocol, f5h leaves it, effective next frame
// - crc is 64 bits with the ecma generator polynomial
// - crc starts at zero, each byte fed lsb first
// - computed crc compared with expected; result on the fail flag
// - only a failing check stores the crc in the readback register
// - readback register cleared at the start of every check
// - readback register cleared on power-up and on any reset
// - readback starts at byte zero; bytes beyond read 00h
// - range check covers start byte address through stop byte address
// - crc computation begins only at the cs rise after the sequence
`timescale 1ns/1ns
`default_nettype none
module flash_pd_quad_crc
	import flash_pd_pkg::*;
#(
	parameter int PD_ENTRY_CYCLES = PD_ENTRY_CYC,
	parameter int PD_RELEASE_CYCLES = PD_RELEASE_CYC,
	parameter int RESET_CYCLES = RESET_RECOVERY_CYC
) (
	// core clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// serial link
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic [3:0] DQ_IN,
	output logic [3:0] DQ_OUT,
	output logic [3:0] DQ_OE,
	// array access and write status
	input wire logic WRITE_BUSY,
	output logic [31:0] ARRAY_ADDR,
	input wire logic [7:0] ARRAY_DATA,
	// status
	output logic DEEP_SLEEP,
	output logic QUAD_MODE,
	output logic CRC_BUSY,
	output logic CRC_FAIL
);
	////////////////////////////////////////////////////////////////////////
	// link domain: clocked by the host serial clock, framed by cs
	logic link_rst;
	logic quad_lk;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [7:0] shift, next_shift;
	logic [7:0] rx_byte, next_rx_byte;
	logic rx_tgl, next_rx_tgl, edge_tgl, next_edge_tgl, byte_done;
	logic [7:0] tx_sh, next_tx_sh, tx_word;
	logic [3:0] dq_out, next_dq_out, dq_oe, next_dq_oe;
	logic [7:0] tx_byte, next_tx_byte;
	logic tx_en, next_tx_en;
	logic quad, next_quad;

	// the link clock stops between frames, so frame state ends with cs
	assign link_rst = RST | CS_N;

	// quad changes only just after cs rises, captured as the frame opens
	always_ff @(negedge CS_N or posedge RST) begin
		if (RST) begin
			quad_lk <= 1'b0;
		end else begin
			quad_lk <= quad;
		end
	end

	always_comb begin
		next_bit_cnt = bit_cnt + 3'd1;
		byte_done = 1'b0;
		next_shift = quad_lk ? {shift[3:0], DQ_IN} : {shift[6:0], DQ_IN[0]};
		if (bit_cnt == (quad_lk ? 3'd1 : 3'd7)) begin
			byte_done = 1'b1;
			next_bit_cnt = 3'd0;
		end
		next_rx_byte = byte_done ? next_shift : rx_byte;
		next_rx_tgl = rx_tgl ^ byte_done;
		next_edge_tgl = ~edge_tgl;
		tx_word = (bit_cnt == 3'd0) ? tx_byte : tx_sh;
		next_dq_out = quad_lk ? tx_word[7:4] : {2'b00, tx_word[7], 1'b0};
		next_tx_sh = quad_lk ? {tx_word[3:0], 4'h0} : {tx_word[6:0], 1'b0};
		next_dq_oe = tx_en ? (quad_lk ? LANE_QUAD : LANE_EXT_OUT) : 4'h0;
	end

	always_ff @(posedge SCLK or posedge link_rst) begin
		if (link_rst) begin
			bit_cnt <= 3'd0;
			shift <= 8'h00;
		end else begin
			bit_cnt <= next_bit_cnt;
			shift <= next_shift;
		end
	end

	// toggles survive cs so that every event reaches the core
	always_ff @(posedge SCLK or posedge RST) begin
		if (RST) begin
			rx_byte <= 8'h00;
			rx_tgl <= 1'b0;
			edge_tgl <= 1'b0;
		end else begin
			rx_byte <= next_rx_byte;
			rx_tgl <= next_rx_tgl;
			edge_tgl <= next_edge_tgl;
		end
	end

	always_ff @(negedge SCLK or posedge link_rst) begin
		if (link_rst) begin
			dq_out <= 4'h0;
			dq_oe <= 4'h0;
			tx_sh <= 8'h00;
		end else begin
			dq_out <= next_dq_out;
			dq_oe <= next_dq_oe;
			tx_sh <= next_tx_sh;
		end
	end

	assign DQ_OUT = dq_out;
	assign DQ_OE = dq_oe;

	////////////////////////////////////////////////////////////////////////
	// core domain: synchronisers for cs and the two link toggles
	logic [2:0] s1, s2, s3;
	logic deselected, cs_rise, rx_evt, edge_evt;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			s1 <= 3'b100;
			s2 <= 3'b100;
			s3 <= 3'b100;
		end else begin
			s1 <= {CS_N, rx_tgl, edge_tgl};
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign deselected = s2[2];
	assign cs_rise = s2[2] & ~s3[2];
	assign rx_evt = s2[1] ^ s3[1];
	assign edge_evt = s2[0] ^ s3[0];

	////////////////////////////////////////////////////////////////////////
	// core domain: command decode, power state and crc sequencing
	crc_bus cb();
	crc64_engine u_crc(.clk(CORE_CLK), .rst(RST), .bus(cb.engine));

	pwr_e pwr, next_pwr;
	crc_e crc_st, next_crc_st;
	logic [TIMER_W-1:0] timer, next_timer;
	logic rst_armed, next_rst_armed;
	logic [4:0] byte_cnt, next_byte_cnt;
	logic [5:0] edge_cnt, next_edge_cnt;
	logic [7:0] opcode, next_opcode, sub, next_sub, option, next_option;
	logic [63:0] expected, next_expected, readback, next_readback;
	logic [31:0] start_addr, next_start_addr, stop_addr, next_stop_addr;
	logic [31:0] addr, next_addr, last_addr, next_last_addr;
	logic [3:0] rb_idx, next_rb_idx;
	logic crc_fail, next_crc_fail, deep_sleep, crc_busy;
	logic crc_clear, crc_valid, one_byte, asleep_ok, need_ok, sw_reset;
	logic [5:0] edges_per_byte;

	always_comb begin
		edges_per_byte = quad ? EDGES_QUAD : EDGES_EXT;
		one_byte = (byte_cnt == 5'd1) && (edge_cnt == edges_per_byte);
		asleep_ok = (pwr == PWR_STANDBY) || (pwr == PWR_DOWN);
		need_ok = (option == OPT_WHOLE) ? (byte_cnt >= CRC_WHOLE_BYTES)
			: (byte_cnt >= CRC_RANGE_BYTES);
		sw_reset = cs_rise && one_byte && asleep_ok && rst_armed
			&& (opcode == OP_RST);
		next_pwr = pwr;
		next_crc_st = crc_st;
		next_timer = (timer != '0) ? timer - 1'b1 : timer;
		next_rst_armed = rst_armed;
		next_byte_cnt = byte_cnt;
		next_edge_cnt = edge_cnt;
		next_opcode = opcode;
		next_sub = sub;
		next_option = option;
		next_expected = expected;
		next_start_addr = start_addr;
		next_stop_addr = stop_addr;
		next_addr = addr;
		next_last_addr = last_addr;
		next_readback = readback;
		next_crc_fail = crc_fail;
		next_quad = quad;
		next_tx_byte = tx_byte;
		next_tx_en = tx_en;
		next_rb_idx = rb_idx;
		crc_clear = 1'b0;
		crc_valid = 1'b0;
		// frame capture
		if (deselected) begin
			next_byte_cnt = 5'd0;
			next_edge_cnt = 6'd0;
			next_tx_en = 1'b0;
		end else begin
			if (edge_evt && edge_cnt != EDGE_CNT_MAX) begin
				next_edge_cnt = edge_cnt + 6'd1;
			end
			if (rx_evt) begin
				if (byte_cnt != BYTE_CNT_MAX) begin
					next_byte_cnt = byte_cnt + 5'd1;
				end
				if (byte_cnt == POS_OPCODE) begin
					next_opcode = rx_byte;
				end else if (byte_cnt == POS_SUB) begin
					next_sub = rx_byte;
				end else if (byte_cnt == POS_OPTION) begin
					next_option = rx_byte;
				end else if (crc_st == CRC_IDLE) begin
					// lsb-first bytes shift in from the top
					if (byte_cnt <= POS_EXP_LAST) begin
						next_expected = {rx_byte, expected[63:8]};
					end else if (byte_cnt <= POS_START_LAST) begin
						next_start_addr = {rx_byte, start_addr[31:8]};
					end else if (byte_cnt <= POS_STOP_LAST) begin
						next_stop_addr = {rx_byte, stop_addr[31:8]};
					end
				end
				// readback: the next byte is ready before its first bit
				if (byte_cnt == POS_OPCODE && rx_byte == OP_READBACK
					&& pwr == PWR_STANDBY) begin
					next_tx_en = 1'b1;
					next_tx_byte = readback[7:0];
					next_rb_idx = 4'd1;
				end else if (tx_en) begin
					next_tx_byte = (rb_idx < RB_BYTES)
						? readback[{rb_idx[2:0], 3'b000} +: 8] : RB_BEYOND;
					if (rb_idx < RB_BYTES) begin
						next_rb_idx = rb_idx + 4'd1;
					end
				end
			end
		end
		// timed power transitions
		case (pwr)
			PWR_ENTERING: begin
				if (timer == '0) next_pwr = PWR_DOWN;
			end
			PWR_WAKING: begin
				if (timer == '0) next_pwr = PWR_STANDBY;
			end
			default: begin
			end
		endcase
		// commands take effect at the cs rise that ends the frame
		if (cs_rise) begin
			next_rst_armed = one_byte && asleep_ok && (opcode == OP_RST_EN);
			if (pwr == PWR_DOWN) begin
				// everything else is dropped, flags and latches untouched
				if (opcode == OP_PD_RELEASE && one_byte) begin
					next_pwr = PWR_WAKING;
					next_timer = TIMER_W'(PD_RELEASE_CYCLES - 1);
				end
			end else if (pwr == PWR_STANDBY && one_byte) begin
				if (opcode == OP_PD_ENTER && !WRITE_BUSY
					&& crc_st == CRC_IDLE) begin
					next_pwr = PWR_ENTERING;
					next_timer = TIMER_W'(PD_ENTRY_CYCLES - 1);
				end else if (opcode == OP_QUAD_ON) begin
					next_quad = 1'b1;
				end else if (opcode == OP_QUAD_OFF) begin
					next_quad = 1'b0;
				end
			end else if (pwr == PWR_STANDBY && opcode == OP_CRC
				&& sub == SUB_CRC && crc_st == CRC_IDLE && need_ok
				&& (option == OPT_WHOLE || option == OPT_RANGE)) begin
				next_crc_st = CRC_FETCH;
				crc_clear = 1'b1;
				next_readback = RB_RESET;
				next_crc_fail = 1'b0;
				next_addr = (option == OPT_RANGE) ? start_addr : 32'h0;
				next_last_addr = (option == OPT_RANGE) ? stop_addr : ARRAY_LAST;
			end
		end
		// array walk, one byte per two cycles
		case (crc_st)
			CRC_FETCH: next_crc_st = CRC_FEED;
			CRC_FEED: begin
				crc_valid = 1'b1;
				if (addr == last_addr) begin
					next_crc_st = CRC_CHECK;
				end else begin
					next_addr = addr + 32'd1;
					next_crc_st = CRC_FETCH;
				end
			end
			CRC_CHECK: begin
				next_crc_st = CRC_IDLE;
				if (cb.value != expected) begin
					next_crc_fail = 1'b1;
					next_readback = cb.value;
				end
			end
			default: begin
			end
		endcase
		if (sw_reset) begin
			next_pwr = PWR_WAKING;
			next_timer = TIMER_W'(RESET_CYCLES - 1);
			next_crc_st = CRC_IDLE;
			next_readback = RB_RESET;
			next_crc_fail = 1'b0;
			next_quad = 1'b0;
		end
	end

	assign cb.clear = crc_clear;
	assign cb.valid = crc_valid;
	assign cb.data = ARRAY_DATA;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			pwr <= PWR_STANDBY;
			crc_st <= CRC_IDLE;
			timer <= '0;
			rst_armed <= 1'b0;
			byte_cnt <= 5'd0;
			edge_cnt <= 6'd0;
			opcode <= 8'h00;
			sub <= 8'h00;
			option <= 8'h00;
			expected <= 64'h0;
			start_addr <= 32'h0;
			stop_addr <= 32'h0;
			addr <= 32'h0;
			last_addr <= 32'h0;
			readback <= RB_RESET;
			crc_fail <= 1'b0;
			quad <= 1'b0;
			tx_byte <= 8'h00;
			tx_en <= 1'b0;
			rb_idx <= 4'd0;
			deep_sleep <= 1'b0;
			crc_busy <= 1'b0;
		end else begin
			pwr <= next_pwr;
			crc_st <= next_crc_st;
			timer <= next_timer;
			rst_armed <= next_rst_armed;
			byte_cnt <= next_byte_cnt;
			edge_cnt <= next_edge_cnt;
			opcode <= next_opcode;
			sub <= next_sub;
			option <= next_option;
			expected <= next_expected;
			start_addr <= next_start_addr;
			stop_addr <= next_stop_addr;
			addr <= next_addr;
			last_addr <= next_last_addr;
			readback <= next_readback;
			crc_fail <= next_crc_fail;
			quad <= next_quad;
			tx_byte <= next_tx_byte;
			tx_en <= next_tx_en;
			rb_idx <= next_rb_idx;
			deep_sleep <= (next_pwr == PWR_DOWN);
			crc_busy <= (next_crc_st != CRC_IDLE);
		end
	end

	assign ARRAY_ADDR = addr;
	assign DEEP_SLEEP = deep_sleep;
	assign QUAD_MODE = quad;
	assign CRC_BUSY = crc_busy;
	assign CRC_FAIL = crc_fail;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb_core @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	property p_enter;
		pwr == PWR_ENTERING && timer == '0 |=> DEEP_SLEEP && pwr == PWR_DOWN;
	endproperty
	a_enter: assert property (p_enter) else $error("sleep not entered");
	property p_reject_busy;
		cs_rise && pwr == PWR_STANDBY && opcode == OP_PD_ENTER && WRITE_BUSY
			|=> pwr == PWR_STANDBY [*2];
	endproperty
	a_reject_busy: assert property (p_reject_busy)
		else $error("entry taken during write");
	property p_ignore;
		cs_rise && pwr == PWR_DOWN && opcode != OP_PD_RELEASE
			&& opcode != OP_RST_EN && opcode != OP_RST
			|=> $stable(QUAD_MODE) && $stable(CRC_FAIL) && pwr == PWR_DOWN;
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("command acted while asleep");
	property p_void;
		cs_rise && pwr == PWR_DOWN && opcode == OP_PD_RELEASE
			&& edge_cnt != edges_per_byte |=> pwr == PWR_DOWN && DEEP_SLEEP;
	endproperty
	a_void: assert property (p_void) else $error("voided release taken");
	property p_release;
		$rose(pwr == PWR_WAKING) |-> !DEEP_SLEEP ##1 pwr != PWR_STANDBY;
	endproperty
	a_release: assert property (p_release)
		else $error("standby reached early");
	property p_quad;
		cs_rise && pwr == PWR_STANDBY && one_byte && opcode == OP_QUAD_ON
			|=> QUAD_MODE;
	endproperty
	a_quad: assert property (p_quad) else $error("quad not entered");
	property p_clear_start;
		crc_clear |=> readback == RB_RESET && CRC_BUSY && !CRC_FAIL;
	endproperty
	a_clear_start: assert property (p_clear_start)
		else $error("readback not cleared at start");
	property p_fail;
		crc_st == CRC_CHECK && cb.value != expected
			|=> CRC_FAIL && readback == $past(cb.value) && !CRC_BUSY;
	endproperty
	a_fail: assert property (p_fail) else $error("fail not reported");
	property p_pass;
		crc_st == CRC_CHECK && cb.value == expected
			|=> !CRC_FAIL && readback == RB_RESET;
	endproperty
	a_pass: assert property (p_pass) else $error("pass left data");
	property p_short;
		cs_rise && opcode == OP_CRC && byte_cnt < CRC_WHOLE_BYTES
			&& crc_st == CRC_IDLE |=> $stable(CRC_FAIL) && crc_st == CRC_IDLE;
	endproperty
	a_short: assert property (p_short)
		else $error("short crc sequence ran");
	property p_beyond;
		tx_en && rx_evt && !deselected && rb_idx == RB_BYTES
			|=> tx_byte == RB_BEYOND;
	endproperty
	a_beyond: assert property (p_beyond)
		else $error("readback beyond end not zero");
endmodule : flash_pd_quad_crc
`default_nettype wire

// [bench/spi_host_model.sv]
// spi host model driving chip select, serial clock and data lines
`timescale 1ns/1ns
`default_nettype none
module spi_host_model
	import flash_pd_pkg::*;
(
	// link lines toward the device
	output logic sclk,
	output logic cs_n,
	output logic [3:0] dq_in,
	// readback lines from the device
	input wire logic [3:0] dq_out,
	input wire logic [3:0] dq_oe
);
	logic [7:0] rd [$];

	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		dq_in = 4'h5;
	end

	// 125 ns period; an undriven line reads unknown so it cannot match
	task automatic tick(output logic [3:0] lanes);
		#61 sclk <= 1'b1;
		for (int j = 0; j < 4; j++)
			lanes[j] = dq_oe[j] ? dq_out[j] : 1'bx;
		#64 sclk <= 1'b0;
	endtask : tick

	// sends only the bytes given, never a write enable of its own
	task automatic frame(input logic [7:0] b [$], input logic quad,
		input int nrd, input int extra);
		int w;
		logic [3:0] x;
		w = quad ? 4 : 1;
		rd = {};
		cs_n <= 1'b0;
		for (int i = 0; i < b.size(); i++) begin
			for (int k = 8 - w; k >= 0; k -= w) begin
				dq_in <= quad ? 4'(b[i] >> k) : {3'b000, b[i][k]};
				tick(x);
			end
		end
		for (int i = 0; i < nrd; i++) begin
			rd.push_back(8'h00);
			for (int k = 8 - w; k >= 0; k -= w) begin
				tick(x);
				if (quad)
					rd[i][k +: 4] = x;
				else
					rd[i][k] = x[1];
			end
		end
		repeat (extra) tick(x);
		// clock stands still; cs rises right after the last edge
		#40 cs_n <= 1'b1;
		dq_in <= ~dq_in;
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [bench/flash_pd_quad_crc_bench.sv]
// self-checking bench of the power-down, quad and crc command block
`timescale 1ns/1ns
`default_nettype none
module flash_pd_quad_crc_bench;
	import flash_pd_pkg::*;
	typedef logic [7:0] bytes_t [$];
	typedef struct {
		logic [31:0] start;
		logic [31:0] stop;
		logic ok;
	} row_s;
	localparam int SHORT = 4;
	localparam int LIMIT = 70000;
	logic core_clk;
	logic rst;
	logic write_busy;
	logic sclk;
	logic cs_n;
	logic [3:0] dq_in;
	logic [3:0] dq_out;
	logic [3:0] dq_oe;
	logic [31:0] array_addr;
	logic [7:0] array_data;
	logic deep_sleep;
	logic quad_mode;
	logic crc_busy;
	logic crc_fail;
	int errors = 0;
	int compares = 0;
	int cycles = 0;
	// a pass between fails shows the readback cleared again
	row_s rows [4] = '{
		'{32'h5, 32'h14, 1'b0},
		'{32'h0, 32'h0, 1'b1},
		'{32'hfe, 32'h103, 1'b0},
		'{32'h30, 32'h33, 1'b0}
	};

	flash_pd_quad_crc #(
		.PD_ENTRY_CYCLES(SHORT),
		.PD_RELEASE_CYCLES(SHORT),
		.RESET_CYCLES(SHORT)
	) i_flash_pd_quad_crc (
		.CORE_CLK(core_clk),
		.RST(rst),
		.SCLK(sclk),
		.CS_N(cs_n),
		.DQ_IN(dq_in),
		.DQ_OUT(dq_out),
		.DQ_OE(dq_oe),
		.WRITE_BUSY(write_busy),
		.ARRAY_ADDR(array_addr),
		.ARRAY_DATA(array_data),
		.DEEP_SLEEP(deep_sleep),
		.QUAD_MODE(quad_mode),
		.CRC_BUSY(crc_busy),
		.CRC_FAIL(crc_fail)
	);
	spi_host_model i_spi_host_model (
		.sclk(sclk),
		.cs_n(cs_n),
		.dq_in(dq_in),
		.dq_out(dq_out),
		.dq_oe(dq_oe)
	);

	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] mem(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction : mem

	function automatic logic [63:0] crc_of(input int s, input int p);
		logic [63:0] c;
		logic [7:0] d;
		c = CRC_INIT;
		for (int a = s; a <= p; a++) begin
			d = mem(32'(a));
			for (int i = 0; i < 8; i++)
				c = {c[62:0], 1'b0} ^ ((c[63] ^ d[i]) ? CRC_POLY : 64'h0);
		end
		return c;
	endfunction : crc_of

	function automatic bytes_t crc_seq(input logic [63:0] e,
		input logic [63:0] span, input logic range);
		bytes_t q;
		q = {OP_CRC, SUB_CRC, range ? OPT_RANGE : OPT_WHOLE};
		for (int i = 0; i < 8; i++)
			q.push_back(e[8*i +: 8]);
		for (int i = 0; range && i < 8; i++)
			q.push_back(span[8*i +: 8]);
		return q;
	endfunction : crc_seq

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc

	task automatic chk_flag(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_flag

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	// gap after each frame covers the cs-high time and short delays
	task automatic send(input bytes_t b, input logic quad, input int nrd,
		input int extra);
		i_spi_host_model.frame(b, quad, nrd, extra);
		cyc(12);
	endtask : send

	// quad readback drives all four lanes, extended only lane one
	task automatic readback(input logic [63:0] exp, input logic quad = 1'b0);
		send({OP_READBACK}, quad, 9, 0);
		for (int i = 0; i < 9; i++)
			chk_byte(i_spi_host_model.rd[i],
				i < 8 ? 8'(exp >> (8 * i)) : RB_BEYOND);
	endtask : readback

	task automatic report_and_stop();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		array_data <= mem(array_addr);
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			errors++;
			report_and_stop();
		end
	end

	// a check must never start while the frame is still open
	always @(posedge crc_busy)
		chk_flag(cs_n, 1'b1);

	initial begin
		logic [63:0] c;
		bytes_t q;
		rst = 1'b1;
		write_busy = 1'b0;
		cyc(6);
		rst <= 1'b0;
		cyc(3);
		chk_flag(deep_sleep | quad_mode | crc_busy | crc_fail, 1'b0);
		readback(64'h0);
		foreach (rows[i]) begin
			c = crc_of(rows[i].start, rows[i].stop);
			send(crc_seq(rows[i].ok ? c : ~c, {rows[i].stop, rows[i].start},
				1'b1), 1'b0, 0, 0);
			for (int k = 0; k < 5000 && crc_busy; k++)
				cyc(1);
			chk_flag(crc_fail, !rows[i].ok);
			readback(rows[i].ok ? 64'h0 : c);
		end
		// a wrongly started whole or range walk would still be busy at the check
		for (int r = 0; r < 2; r++) begin
			q = crc_seq(64'h0, {32'hff, 32'h0}, r[0]);
			q.pop_back();
			send(q, 1'b0, 0, 0);
			chk_flag(crc_busy, 1'b0);
			chk_flag(crc_fail, 1'b1);
		end
		send({OP_QUAD_ON}, 1'b0, 0, 0);
		chk_flag(quad_mode, 1'b1);
		send({OP_QUAD_OFF}, 1'b1, 0, 0);
		chk_flag(quad_mode, 1'b0);
		write_busy <= 1'b1;
		send({OP_PD_ENTER}, 1'b0, 0, 0);
		chk_flag(deep_sleep, 1'b0);
		write_busy <= 1'b0;
		send({OP_PD_ENTER}, 1'b0, 0, 0);
		chk_flag(deep_sleep, 1'b1);
		send({OP_QUAD_ON}, 1'b0, 0, 0);
		send(crc_seq(64'h0, 64'h0, 1'b0), 1'b0, 0, 0);
		chk_flag(quad_mode | crc_busy, 1'b0);
		chk_flag(crc_fail, 1'b1);
		send({OP_PD_RELEASE}, 1'b0, 0, 1);
		chk_flag(deep_sleep, 1'b1);
		send({OP_PD_RELEASE}, 1'b0, 0, 0);
		chk_flag(deep_sleep, 1'b0);
		send({OP_QUAD_ON}, 1'b0, 0, 0);
		chk_flag(quad_mode, 1'b1);
		readback(c, 1'b1);
		send({OP_PD_ENTER}, 1'b1, 0, 0);
		chk_flag(deep_sleep, 1'b1);
		send({OP_RST_EN}, 1'b1, 0, 0);
		send({OP_RST}, 1'b1, 0, 0);
		chk_flag(deep_sleep | quad_mode | crc_fail, 1'b0);
		readback(64'h0);
		send(crc_seq(64'h1, 64'h0, 1'b0), 1'b0, 0, 0);
		chk_flag(crc_busy, 1'b1);
		chk_flag(array_addr < 32'h40, 1'b1);
		rst <= 1'b1;
		cyc(2);
		rst <= 1'b0;
		cyc(3);
		chk_flag(crc_busy | crc_fail, 1'b0);
		chk_flag(array_addr == 32'h0, 1'b1);
		readback(64'h0);
		report_and_stop();
	end
endmodule : flash_pd_quad_crc_bench
`default_nettype wire
